// File: hdl/plls_pkg.sv
// Shared constants and types for the PHY lamp, late-collision and pair-status registers.
// Assumes a 125 MHz core clock and an AXI4-Lite register port with 32-bit data.
package plls_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_LAMP_SEL = 6'h1c;
    localparam logic [5:0] IDX_BLINK = 6'h1d;
    localparam logic [5:0] IDX_LATE = 6'h1e;
    localparam logic [5:0] IDX_PAIR = 6'h1f;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h21;
    localparam logic [5:0] IDX_IRQ_EN = 6'h22;
    // Blink register fields and reset values
    localparam int BLINK_ADDR_LSB = 14;
    localparam int BLINK_RATIO_LSB = 8;
    localparam logic [5:0] BLINK_RATIO_RST = 6'h1f;
    localparam logic [7:0] BLINK_PAT_RST = 8'h55;
    // Pair status bit positions
    localparam int PAIR_UPPER_SEL_BIT = 15;
    localparam int PAIR_SWAP_BIT = 14;
    localparam int PAIR_POL3_BIT = 13;
    // Selector defaults for each strap level, lamps 3..0 = low, mid, gig, then link/activity (strap 0) or link (strap 1)
    localparam logic [15:0] LAMP_SEL_STRAP0 = 16'h210a;
    localparam logic [15:0] LAMP_SEL_STRAP1 = 16'h2104;
    // Blink time base: one tick every 2 ms
    localparam int CLK_PERIOD_NS = 8;
    localparam int BLINK_TICK_NS = 2000000;
    localparam int BLINK_TICK_CYCLES = BLINK_TICK_NS / CLK_PERIOD_NS;
    // Late-collision bin limits in byte positions
    localparam logic [8:0] BIN0_LO = 9'h040;
    localparam logic [8:0] BIN1_LO = 9'h060;
    localparam logic [8:0] BIN2_LO = 9'h080;
    localparam logic [8:0] BIN3_LO = 9'h0c0;
    localparam logic [8:0] BIN3_HI = 9'h13f;
    localparam logic [7:0] CNT_MAX = 8'hff;
    // Link speed codes and AXI responses
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Lamp selector codes (standard modes)
    typedef enum logic [3:0] {
        LM_GIG = 4'h0, LM_MID = 4'h1, LM_LOW = 4'h2, LM_GIG_ON_MID_BLINK = 4'h3,
        LM_LINK = 4'h4, LM_TX = 4'h5, LM_RX = 4'h6, LM_ACT = 4'h7,
        LM_FDX = 4'h8, LM_COL = 4'h9, LM_LINK_ACT = 4'ha, LM_LINK_TX = 4'hb,
        LM_LINK_RX = 4'hc, LM_BLINK = 4'hd, LM_ON = 4'he, LM_OFF = 4'hf
    } plls_lamp_mode_t;
    // Live PHY state feeding the lamps
    typedef struct packed {
        logic link_up;
        logic [1:0] speed;
        logic full_duplex;
        logic tx_act;
        logic rx_act;
        logic collision;
    } plls_phy_state_t;
    // Late collision report from the transmit path
    typedef struct packed {
        logic valid;
        logic [8:0] byte_pos;
    } plls_late_col_t;
endpackage

// File: hdl/plls_regs.sv
// PHY lamp selectors, blink generator, late-collision histogram and pair status.
// Assumes PHY state inputs come from logic on aclk; only the strap pin is asynchronous.
`timescale 1ns/1ns
module plls_regs
    import plls_pkg::*;
#(
    parameter int TICK_CYCLES = BLINK_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lamp_strap_pin,
    input wire plls_phy_state_t phy_state,
    input wire plls_late_col_t late_col,
    input wire logic late_bin_count_enable,
    input wire logic dim_two_three_swapped,
    input wire logic dim_three_polarity_inverted,
    output logic [3:0] lamp_out,
    output logic irq
);
    // Lamp decode, shared by all four lamps
    function automatic logic lamp_decode(input logic [3:0] sel, input plls_phy_state_t s,
                                         input logic blink);
        logic lk, act;
        lk = s.link_up;
        act = s.tx_act | s.rx_act;
        case (plls_lamp_mode_t'(sel))
            LM_GIG: lamp_decode = lk && s.speed == SPD_1000;
            LM_MID: lamp_decode = lk && s.speed == SPD_100;
            LM_LOW: lamp_decode = lk && s.speed == SPD_10;
            LM_GIG_ON_MID_BLINK: lamp_decode = lk && (s.speed == SPD_1000 ||
                                                      (s.speed == SPD_100 && blink));
            LM_LINK: lamp_decode = lk;
            LM_TX: lamp_decode = s.tx_act;
            LM_RX: lamp_decode = s.rx_act;
            LM_ACT: lamp_decode = act;
            LM_FDX: lamp_decode = s.full_duplex;
            LM_COL: lamp_decode = s.collision;
            LM_LINK_ACT: lamp_decode = lk && (!act || blink);
            LM_LINK_TX: lamp_decode = lk && (!s.tx_act || blink);
            LM_LINK_RX: lamp_decode = lk && (!s.rx_act || blink);
            LM_BLINK: lamp_decode = blink;
            LM_ON: lamp_decode = 1'b1;
            default: lamp_decode = 1'b0;
        endcase
    endfunction

    // Bus handshake flops
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    logic [5:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    // Register state
    logic [15:0] lamp_sel_q;
    logic [1:0] blink_addr_q;
    logic [5:0] ratio_q [4];
    logic [7:0] pat_q [4];
    logic [7:0] cnt_q [4];
    logic upper_sel_q;
    logic swap_q, pol3_q;
    logic [2:0] irq_stat_q, irq_en_q;
    logic irq_q;
    logic [3:0] lamp_q;
    logic [2:0] strap_sync_q;
    logic strap_done_q;
    logic [1:0] strap_fill_q;
    logic [17:0] tick_cnt_q;
    logic any_sat_prev_q;

    // Handshakes and decoded access
    wire aw_hs = s_axi_awvalid && awready_q;
    wire w_hs = s_axi_wvalid && wready_q;
    wire ar_hs = s_axi_arvalid && arready_q;
    wire wr_go = aw_got_q && w_got_q && !bvalid_q;
    wire [5:0] ar_idx = s_axi_araddr[7:2];
    wire wr_lamp = wr_go && aw_idx_q == IDX_LAMP_SEL;
    wire wr_blink = wr_go && aw_idx_q == IDX_BLINK;
    wire wr_clr = wr_go && aw_idx_q == IDX_IRQ_CLR;
    wire wr_en = wr_go && aw_idx_q == IDX_IRQ_EN;
    wire wr_ok = aw_idx_q inside {IDX_LAMP_SEL, IDX_BLINK, IDX_LATE, IDX_PAIR,
                                  IDX_IRQ_STAT, IDX_IRQ_CLR, IDX_IRQ_EN};
    wire rd_ok = ar_idx inside {IDX_LAMP_SEL, IDX_BLINK, IDX_LATE, IDX_PAIR,
                                IDX_IRQ_STAT, IDX_IRQ_EN};
    wire rd_late = ar_hs && ar_idx == IDX_LATE;
    wire rd_lower = rd_late && !upper_sel_q;
    wire rd_upper = rd_late && upper_sel_q;

    // Write address and data taken in either order; response once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            aw_idx_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
                aw_idx_q <= s_axi_awaddr[7:2];
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Read mux; the late pair follows the upper select
    wire [15:0] late_word = upper_sel_q ? {cnt_q[3], cnt_q[2]} : {cnt_q[1], cnt_q[0]};
    wire [15:0] blink_word = {blink_addr_q, ratio_q[blink_addr_q], pat_q[blink_addr_q]};
    wire [15:0] pair_word = {upper_sel_q, swap_q, pol3_q, 13'h0000};
    wire [15:0] rd_mux = ar_idx == IDX_LAMP_SEL ? lamp_sel_q :
                         ar_idx == IDX_BLINK ? blink_word :
                         ar_idx == IDX_LATE ? late_word :
                         ar_idx == IDX_PAIR ? pair_word :
                         ar_idx == IDX_IRQ_STAT ? {13'h0000, irq_stat_q} :
                         ar_idx == IDX_IRQ_EN ? {13'h0000, irq_en_q} : 16'h0000;

    // One read in flight; arready drops until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_mux};
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Strap pin passes three flops; selectors load once stages two and three agree
    // Fill count keeps the reset zeros from posing as a settled strap level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_sync_q <= 3'h0;
            strap_fill_q <= 2'h0;
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], lamp_strap_pin};
            strap_fill_q <= strap_fill_q == 2'h3 ? 2'h3 : strap_fill_q + 2'h1;
        end
    end
    wire strap_stable = strap_fill_q == 2'h3 && strap_sync_q[1] == strap_sync_q[2];

    // Selector register; a write landing with the strap load still wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_sel_q <= LAMP_SEL_STRAP0;
            strap_done_q <= 1'b0;
        end else begin
            if (!strap_done_q && strap_stable) begin
                strap_done_q <= 1'b1;
                lamp_sel_q <= strap_sync_q[2] ? LAMP_SEL_STRAP1 : LAMP_SEL_STRAP0;
            end
            if (wr_lamp && wstrb_q[0]) lamp_sel_q[7:0] <= wdata_q[7:0];
            if (wr_lamp && wstrb_q[1]) lamp_sel_q[15:8] <= wdata_q[15:8];
        end
    end

    // Set address follows the write; fields go to the set it names
    wire [1:0] blink_wr_bank = wstrb_q[1] ? wdata_q[15:14] : blink_addr_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) blink_addr_q <= 2'h0;
        else if (wr_blink && wstrb_q[1]) blink_addr_q <= wdata_q[15:BLINK_ADDR_LSB];
    end

    // Shared 2 ms time base for all blink generators
    wire tick = tick_cnt_q == 18'(TICK_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) tick_cnt_q <= 18'h00000;
        else tick_cnt_q <= tick ? 18'h00000 : tick_cnt_q + 18'h00001;
    end

    // Per-lamp blink set, divider, pattern walker and output flop
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lamp
            logic [5:0] div_q;
            logic [2:0] bit_q;
            wire bank_hit = wr_blink && blink_wr_bank == 2'(g);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ratio_q[g] <= BLINK_RATIO_RST;
                    pat_q[g] <= BLINK_PAT_RST;
                end else begin
                    if (bank_hit && wstrb_q[1]) ratio_q[g] <= wdata_q[13:BLINK_RATIO_LSB];
                    if (bank_hit && wstrb_q[0]) pat_q[g] <= wdata_q[7:0];
                end
            end
            // Each pattern bit lasts ratio+1 ticks: 32 x 2 ms x 8 bits = 512 ms
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    div_q <= 6'h00;
                    bit_q <= 3'h0;
                end else if (tick) begin
                    if (div_q >= ratio_q[g]) begin
                        div_q <= 6'h00;
                        bit_q <= bit_q + 3'h1;
                    end else begin
                        div_q <= div_q + 6'h01;
                    end
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) lamp_q[g] <= 1'b0;
                else lamp_q[g] <= lamp_decode(lamp_sel_q[4*g +: 4], phy_state,
                                              pat_q[g][bit_q]);
            end
        end
    endgenerate

    // Bin selection by byte position of the collision
    wire [8:0] bp = late_col.byte_pos;
    wire [3:0] bin_hit = {bp >= BIN3_LO && bp <= BIN3_HI, bp >= BIN2_LO && bp < BIN3_LO,
                          bp >= BIN1_LO && bp < BIN2_LO, bp >= BIN0_LO && bp < BIN1_LO};
    wire any_sat = cnt_q[0] == CNT_MAX || cnt_q[1] == CNT_MAX ||
                   cnt_q[2] == CNT_MAX || cnt_q[3] == CNT_MAX;
    // Counting needs the enable, half duplex, no freeze and no saturation
    wire count_ok = late_col.valid && late_bin_count_enable && !phy_state.full_duplex &&
                    !upper_sel_q && !any_sat && !rd_late;

    // Counters: a read of the upper pair clears, otherwise bins count
    generate
        for (g = 0; g < 4; g++) begin : g_cnt
            always_ff @(posedge aclk) begin
                if (!aresetn || rd_upper) cnt_q[g] <= 8'h00;
                else if (count_ok && bin_hit[g]) cnt_q[g] <= cnt_q[g] + 8'h01;
            end
        end
    endgenerate

    // Upper select toggles on each read of the counter register
    always_ff @(posedge aclk) begin
        if (!aresetn || rd_upper) upper_sel_q <= 1'b0;
        else if (rd_lower) upper_sel_q <= 1'b1;
    end

    // Pair status; polarity only meaningful on a gigabit link
    wire pol3_d = dim_three_polarity_inverted && phy_state.link_up &&
                  phy_state.speed == SPD_1000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_q <= 1'b0;
            pol3_q <= 1'b0;
        end else begin
            swap_q <= dim_two_three_swapped;
            pol3_q <= pol3_d;
        end
    end

    // Sticky events: saturation, swap and polarity rising; set beats clear
    wire [2:0] irq_evt = {pol3_d && !pol3_q, dim_two_three_swapped && !swap_q,
                          any_sat && !any_sat_prev_q};
    wire [2:0] irq_stat_d = irq_evt | (irq_stat_q & ~(wr_clr ? wdata_q[2:0] : 3'h0));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'h0;
            irq_en_q <= 3'h0;
            irq_q <= 1'b0;
            any_sat_prev_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            any_sat_prev_q <= any_sat;
            if (wr_en && wstrb_q[0]) irq_en_q <= wdata_q[2:0];
            irq_q <= |(irq_stat_d & (wr_en && wstrb_q[0] ? wdata_q[2:0] : irq_en_q));
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign lamp_out = lamp_q;
    assign irq = irq_q;

    // Checks on the sequenced counter read, saturation, lamps and status
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_LOWER_READ_SELECTS: assert property (rd_lower |=> upper_sel_q)
        else $error("lower pair read did not set upper select");
    AST_FROZEN_HOLD: assert property (upper_sel_q && !rd_upper |=>
        cnt_q[0] == $past(cnt_q[0]) && cnt_q[3] == $past(cnt_q[3]))
        else $error("counters moved while frozen");
    AST_UPPER_READ_CLEARS: assert property (rd_upper |=> !upper_sel_q &&
        cnt_q[0] == 8'h00 && cnt_q[1] == 8'h00 && cnt_q[2] == 8'h00)
        else $error("upper pair read did not clear");
    AST_PAIR_DATA: assert property (rd_lower |=> rdata_q[15:0] == {$past(cnt_q[1]),
        $past(cnt_q[0])})
        else $error("lower pair read data wrong");
    AST_SAT_STOPS: assert property (any_sat && !rd_upper |=>
        cnt_q[1] == $past(cnt_q[1]) && cnt_q[2] == $past(cnt_q[2]))
        else $error("counter moved after saturation");
    AST_NO_WRAP: assert property (cnt_q[0] == CNT_MAX && !rd_upper |=> cnt_q[0] == CNT_MAX)
        else $error("counter wrapped");
    AST_BLINK_RESET: assert property ($past(!aresetn) |-> ratio_q[0] == BLINK_RATIO_RST &&
        pat_q[3] == BLINK_PAT_RST)
        else $error("blink set reset values wrong");
    AST_LAMP_FDX: assert property (lamp_sel_q[3:0] == 4'h8 |=>
        lamp_q[0] == $past(phy_state.full_duplex))
        else $error("full duplex lamp wrong");
    AST_LAMP_GIG: assert property (lamp_sel_q[7:4] == 4'h0 |=>
        lamp_q[1] == $past(phy_state.link_up && phy_state.speed == SPD_1000))
        else $error("gigabit lamp wrong");
    AST_POL3_GIG: assert property (pol3_q |-> $past(phy_state.speed) == SPD_1000)
        else $error("pair 3 polarity outside gigabit");
    AST_SWAP_FOLLOWS: assert property (##1 swap_q == $past(dim_two_three_swapped))
        else $error("swap status stale");
    COV_LATE_COUNT: cover property (count_ok ##1 rd_lower ##[1:20] rd_upper);
    COV_SATURATE: cover property (!any_sat ##1 any_sat);
    COV_IRQ: cover property (!irq_q ##1 irq_q);
endmodule

// File: verif/plls_mgmt.sv
// Management station model: AXI4-Lite master, one write or read at a time.
// Assumes callers enter the tasks just after a rising aclk edge.
`timescale 1ns/1ns
module plls_mgmt (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int tmo = 0;
    // Idle bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    end
    // Each channel is held until its own ready; no fixed latency assumed
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (n >= 200) tmo++;
        // One idle edge so a following call never reassigns a signal in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
        s_axi_rready <= 1'b0;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        if (n >= 200) tmo++;
        @(posedge aclk);
    endtask
endmodule

// File: verif/plls_regs_tb.sv
// Bench: integer model of lamps, counters and status, compared at every read.
// Assumes plls_mgmt drives the register port; PHY inputs are driven here.
`timescale 1ns/1ns
module plls_regs_tb
    import plls_pkg::*;
;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, lamp_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic aclk = 0, aresetn = 0, lamp_strap_pin = 0, late_bin_count_enable = 0;
    logic dim_two_three_swapped = 0, dim_three_polarity_inverted = 0;
    plls_phy_state_t phy_state = '0;
    plls_late_col_t late_col = '0;
    int error_cnt = 0, n_checks = 0, cnt[4] = '{default: 0}, n;
    int codes[11] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 14, 15};
    int pos[10] = '{63, 64, 95, 96, 127, 128, 191, 192, 319, 320};
    // Blinking lamp codes and a PHY state that makes each one follow the pattern
    int bc[4] = '{3, 10, 11, 12};
    logic [6:0] bs[4] = '{7'h50, 7'h64, 7'h64, 7'h62};
    bit sel = 0;
    always #4 aclk = ~aclk;
    // Short blink tick keeps a full pattern period at 64 cycles
    plls_regs #(.TICK_CYCLES(4)) dut_u (.*);
    plls_mgmt mgmt_u (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        mgmt_u.rd(a, d, r);
        chk(nm, e, d);
        chk(nm, (a == 8'hfc) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY), 32'(r));
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask
    // Model bins a pulse unless frozen, saturated, disabled or full duplex
    task automatic pulse(input int p);
        int b;
        b = p < 64 ? -1 : p < 96 ? 0 : p < 128 ? 1 : p < 192 ? 2 : p < 320 ? 3 : -1;
        if (b >= 0 && late_bin_count_enable && !phy_state.full_duplex && !sel &&
            cnt[0] < 255 && cnt[1] < 255 && cnt[2] < 255 && cnt[3] < 255) cnt[b]++;
        late_col <= {1'b1, 9'(p)};
        tick(1);
        late_col.valid <= 1'b0;
        tick(1);
    endtask
    task automatic rcnt();
        rchk("counts", 8'h78, sel ? {16'h0, 8'(cnt[3]), 8'(cnt[2])} :
            {16'h0, 8'(cnt[1]), 8'(cnt[0])});
        if (sel) cnt = '{default: 0};
        sel = !sel;
    endtask
    function automatic logic lit(input int c, input plls_phy_state_t s);
        case (c)
            0: return s.link_up && s.speed == SPD_1000;
            1: return s.link_up && s.speed == SPD_100;
            2: return s.link_up && s.speed == SPD_10;
            4: return s.link_up;
            5: return s.tx_act;
            6: return s.rx_act;
            7: return s.tx_act || s.rx_act;
            8: return s.full_duplex;
            9: return s.collision;
            14: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    task automatic conclude();
        error_cnt += mgmt_u.tmo;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #800000;
        error_cnt++;
        conclude();
    end
    // A bus wait that ran out ends the run here
    always @(posedge aclk) if (mgmt_u.tmo > 0) conclude();
    initial begin
        n = $urandom(35406);
        tick(8);
        aresetn <= 1'b1;
        tick(6);
        rchk("sel rst", 8'h70, 32'h210a);
        rchk("blink rst", 8'h74, 32'h1f55);
        rchk("pair rst", 8'h7c, 32'h0);
        rchk("unmapped", 8'hfc, 32'h0);
        mgmt_u.wr(8'hfc, 32'h1, r);
        chk("wr unmapped", 32'(RESP_SLVERR), 32'(r));
        $display("test reset done");
        foreach (codes[i]) begin
            mgmt_u.wr(8'h70, {16'h0, {4{4'(codes[i])}}}, r);
            rchk("sel", 8'h70, {16'h0, {4{4'(codes[i])}}});
            repeat (4) begin
                phy_state <= {1'($urandom), 2'($urandom % 3), 4'($urandom)};
                tick(2);
                chk("lamp", {28'h0, {4{lit(codes[i], phy_state)}}}, 32'(lamp_out));
            end
        end
        $display("test lamps done");
        mgmt_u.wr(8'h74, 32'hc101, r);
        rchk("blink", 8'h74, 32'hc101);
        mgmt_u.wr(8'h70, 32'hd000, r);
        n = 0;
        repeat (64) begin
            tick(1);
            n += lamp_out[3];
        end
        chk("lit cycles", 32'd8, 32'(n));
        foreach (bc[i]) begin
            mgmt_u.wr(8'h70, {16'h0, 4'(bc[i]), 12'h0}, r);
            phy_state <= bs[i];
            tick(1);
            n = 0;
            repeat (64) begin
                tick(1);
                n += lamp_out[3];
            end
            chk("blink mode", 32'd8, 32'(n));
        end
        $display("test blink done");
        phy_state <= '0;
        late_bin_count_enable <= 1'b1;
        tick(1);
        foreach (pos[i]) pulse(pos[i]);
        phy_state.full_duplex <= 1'b1;
        tick(1);
        pulse(100);
        {phy_state.full_duplex, late_bin_count_enable} <= 2'b00;
        tick(1);
        pulse(100);
        late_bin_count_enable <= 1'b1;
        tick(1);
        rcnt();
        rchk("sel set", 8'h7c, 32'h8000);
        pulse(100);
        rcnt();
        rchk("sel clr", 8'h7c, 32'h0);
        repeat (256) pulse(64);
        pulse(200);
        rcnt();
        rcnt();
        $display("test counters done");
        rchk("sat stat", 8'h80, 32'h1);
        mgmt_u.wr(8'h88, 32'h0, r);
        mgmt_u.wr(8'h84, 32'h7, r);
        dim_two_three_swapped <= 1'b1;
        tick(4);
        chk("irq masked", 32'h0, 32'(irq));
        rchk("status", 8'h80, 32'h2);
        mgmt_u.wr(8'h88, 32'h2, r);
        tick(2);
        chk("irq on", 32'h1, 32'(irq));
        phy_state <= {1'b1, SPD_1000, 4'h0};
        dim_three_polarity_inverted <= 1'b1;
        tick(4);
        rchk("pair gig", 8'h7c, 32'h6000);
        rchk("status", 8'h80, 32'h6);
        mgmt_u.wr(8'h84, 32'h6, r);
        tick(2);
        chk("irq clr", 32'h0, 32'(irq));
        phy_state.speed <= SPD_100;
        tick(4);
        rchk("pair mid", 8'h7c, 32'h4000);
        $display("test status done");
        conclude();
    end
endmodule
